// File: sim/tb_transmitter_operate_auto_control.sv
// self-checking bench for the transmitter control block
`timescale 1ns/100ps
`default_nettype none
module tb_transmitter_operate_auto_control;
   logic i_ref_clk = 1'h0, i_rst = 1'h1, i_operate_standby_switch_op = 1'h0;
   logic i_operate_standby_switch_sb = 1'h0, i_auto_manual_switch_auto = 1'h0;
   logic i_auto_manual_switch_man = 1'h0, i_interlock_input_n = 1'h0;
   logic i_video_fault_input_n = 1'h1;
   logic i_rx_alc_fault = 1'h0, i_overtemp_fault = 1'h0, i_vswr_over_limit = 1'h0;
   logic [3:0] i_alc = 4'h0, o_alc, o_tray_enable;
   logic o_standby_indicator, o_operate_indicator, o_automatic_indicator, o_manual_indicator;
   logic o_interlock_indicator, o_video_loss_indicator, o_cutback, o_amp_disable_a;
   logic o_amp_disable_b, o_remote_operate_out_n, o_remote_auto_out_n;
   logic o_remote_manual_out_n, o_operating, rf_on;
   int err_count = 0, n_tests = 0, cyc = 0;
   // row bits: op sb auto man interlock_n overtemp vswr | operating auto
   logic [8:0] rows [11] = '{9'h102, 9'h084, 9'h180, 9'h110, 9'h002, 9'h008,
      9'h002, 9'h043, 9'h083, 9'h062, 9'h010};
   transmitter_operate_auto_control #(.VIDEO_HOLD_CYC(32'h8))
      transmitter_operate_auto_control_i (.*);
   tray_model tray_model_i (.i_tray_enable(o_tray_enable), .i_amp_disable_a(o_amp_disable_a),
      .i_amp_disable_b(o_amp_disable_b), .o_rf_on(rf_on));
   always #50 i_ref_clk = ~i_ref_clk;
   task automatic w(input int n);
      repeat (n) @(posedge i_ref_clk);
   endtask
   task automatic chk(input string nm, input logic [3:0] ex, input logic [3:0] got);
      n_tests++;
      if (got !== ex) begin
         $display("[ERR] %s expected %h seen %h", nm, ex, got);
         err_count++;
      end
   endtask
   task automatic complete_run;
      $display("checks %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // hang guard, the whole sequence needs well under a thousand cycles
   always @(posedge i_ref_clk) begin
      cyc++;
      if (cyc == 2000) begin
         err_count++;
         complete_run;
      end
   end
   initial begin
      w(6);
      i_rst <= 1'h0;
      w(1);
      chk("reset standby", 4'h1, o_standby_indicator);
      chk("reset remote manual", 4'h0, o_remote_manual_out_n);
      chk("reset trays", 4'h0, o_tray_enable);
      // commands held as levels for four cycles each row
      for (int k = 0; k < 11; k++) begin
         {i_operate_standby_switch_op, i_operate_standby_switch_sb, i_auto_manual_switch_auto,
            i_auto_manual_switch_man, i_interlock_input_n, i_overtemp_fault,
            i_vswr_over_limit} <= rows[k][8:2];
         i_alc <= 4'(k + 3);
         w(4);
         chk("operating", rows[k][1], o_operating);
         chk("operate lamp", rows[k][1], o_operate_indicator);
         chk("alc", rows[k][1] ? 4'(k + 3) : 4'h0, o_alc);
         chk("auto lamp", rows[k][0], o_automatic_indicator);
         chk("manual lamp", !rows[k][0], o_manual_indicator);
         chk("trays keyed", rows[k][1], rf_on);
         chk("cutback", rows[k][2], o_cutback);
      end
      // latch stayed set, interlock back gives operate; auto is pressed in the same cycle
      {i_interlock_input_n, i_auto_manual_switch_auto} <= 2'h1;
      w(1);
      i_auto_manual_switch_auto <= 1'h0;
      i_rx_alc_fault <= 1'h1;
      w(4);
      chk("alc fault standby", 4'h0, o_operating);
      i_rx_alc_fault <= 1'h0;
      w(4);
      chk("alc fault recover", 4'h1, o_operating);
      i_video_fault_input_n <= 1'h0;
      w(2);
      chk("video lamp", 4'h1, o_video_loss_indicator);
      w(3);
      chk("video not yet", 4'h1, o_operating);
      w(10);
      chk("video standby", 4'h0, o_operating);
      i_video_fault_input_n <= 1'h1;
      w(4);
      chk("video recover", 4'h1, o_operating);
      chk("video lamp off", 4'h0, o_video_loss_indicator);
      {i_auto_manual_switch_man, i_video_fault_input_n} <= 2'h2;
      w(16);
      chk("manual ignores loss", 4'h1, o_operating);
      // back to auto with video restored, then a reset in mid-run
      {i_auto_manual_switch_man, i_auto_manual_switch_auto, i_video_fault_input_n} <= 3'h3;
      w(4);
      chk("remote auto", 4'h0, o_remote_auto_out_n);
      chk("remote manual off", 4'h1, o_remote_manual_out_n);
      chk("interlock lamp", 4'h1, o_interlock_indicator);
      chk("auto operating", 4'h1, o_operating);
      i_auto_manual_switch_auto <= 1'h0;
      i_rst <= 1'h1;
      w(2);
      i_rst <= 1'h0;
      w(1);
      chk("mid reset standby", 4'h1, o_standby_indicator);
      chk("mid reset remote auto", 4'h1, o_remote_auto_out_n);
      chk("mid reset interlock", 4'h0, o_interlock_indicator);
      // both latches must come back cleared, so operate stays off
      w(2);
      chk("latches cleared", 4'h0, o_operating);
      chk("manual after reset", 4'h1, o_manual_indicator);
      chk("interlock lamp back", 4'h1, o_interlock_indicator);
      complete_run;
   end
endmodule
`default_nettype wire

// File: sim/tray_model.sv
// amplifier tray model on the far side of the control block
`timescale 1ns/100ps
`default_nettype none
module tray_model (
   input wire logic [3:0] i_tray_enable,
   input wire logic i_amp_disable_a,
   input wire logic i_amp_disable_b,
   output logic o_rf_on
);
   // a tray keys up only with every enable and neither disable
   assign o_rf_on = &i_tray_enable && !i_amp_disable_a && !i_amp_disable_b;
endmodule
`default_nettype wire

// File: sim/txctl_assertions.sv
// concurrent checks on the control block ports
`timescale 1ns/100ps
`default_nettype none
module txctl_assertions (
   input wire logic i_ref_clk,
   input wire logic i_rst,
   input wire logic i_operate_standby_switch_sb,
   input wire logic i_auto_manual_switch_auto,
   input wire logic i_auto_manual_switch_man,
   input wire logic i_interlock_input_n,
   input wire logic i_video_fault_input_n,
   input wire logic i_rx_alc_fault,
   input wire logic i_overtemp_fault,
   input wire logic i_vswr_over_limit,
   input wire logic o_standby_indicator,
   input wire logic o_manual_indicator,
   input wire logic o_interlock_indicator,
   input wire logic o_video_loss_indicator,
   input wire logic o_cutback,
   input wire logic o_amp_disable_a,
   input wire logic [3:0] o_tray_enable,
   input wire logic o_remote_operate_out_n,
   input wire logic o_remote_auto_out_n,
   input wire logic o_remote_manual_out_n,
   input wire logic o_operating
);
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (i_rst);
   // mode lamps lag the latch, so a fresh mode command is excluded
   sequence man_sb;
      i_operate_standby_switch_sb && o_manual_indicator && !$past(i_auto_manual_switch_auto);
   endsequence
   sequence auto_flt;
      i_rx_alc_fault && !o_manual_indicator && !$past(i_auto_manual_switch_man);
   endsequence
   lamp_pair_a: assert property (o_standby_indicator == !o_operating)
      else $error("standby lamp disagrees with operate state");
   tray_en_a: assert property (o_tray_enable == (o_operating ? 4'hf : 4'h0))
      else $error("tray enables disagree with operate state");
   amp_dis_a: assert property (o_amp_disable_a != o_operating)
      else $error("amplifier disable disagrees with operate state");
   remote_op_a: assert property (o_remote_operate_out_n == !o_operating)
      else $error("remote operate output wrong");
   remote_mode_a: assert property (o_remote_manual_out_n != o_remote_auto_out_n)
      else $error("remote auto and manual outputs both equal");
   mode_lamp_a: assert property (o_remote_manual_out_n == !o_manual_indicator)
      else $error("remote manual output disagrees with manual lamp");
   il_lamp_a: assert property (!$past(i_rst) |->
      o_interlock_indicator == !$past(i_interlock_input_n))
      else $error("interlock lamp wrong");
   vid_lamp_a: assert property (!$past(i_rst) |->
      o_video_loss_indicator == !$past(i_video_fault_input_n))
      else $error("video loss lamp does not follow video input");
   cutback_a: assert property (!$past(i_rst) |-> o_cutback == $past(i_vswr_over_limit))
      else $error("cutback does not follow vswr");
   op_qual_a: assert property (
      (i_interlock_input_n || i_overtemp_fault) |=> !o_operating)
      else $error("operate without interlock or with overtemperature");
   man_standby_a: assert property (man_sb |-> ##2 !o_operating)
      else $error("standby command ignored in manual");
   auto_fault_a: assert property (auto_flt ##1 auto_flt |-> ##2 !o_operating)
      else $error("receiver fault in auto kept operate");
endmodule
bind transmitter_operate_auto_control txctl_assertions txctl_assertions_i (.*);
`default_nettype wire

// File: src/cmd_latch.sv
// set/clear latch standing in for a magnetic latching relay
`timescale 1ns/100ps
`default_nettype none
module cmd_latch #(
   parameter logic RST_VAL = 1'h0
) (
   input wire logic i_ref_clk,
   input wire logic i_rst,
   input wire logic i_set,
   input wire logic i_clr,
   output logic o_q
);
   // clear beats set, like an opening relay coil overriding
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         o_q <= RST_VAL;
      end else if (i_clr) begin
         o_q <= 1'h0; // [RULE21]
      end else if (i_set) begin
         o_q <= 1'h1;
      end
   end
endmodule
`default_nettype wire

// File: src/transmitter_operate_auto_control.sv
// transmitter operate/standby and auto/manual control with indicator drive
// How it works
// [RULE1] operate is only entered while the active-low interlock is present
// [RULE2] green interlock indicator lights while the interlock is present
// [RULE3] vswr over the limit asserts output cutback to hold vswr at limit
// [RULE4] operate latch: operate sets, standby clears, otherwise holds
// [RULE5] operate needs latch set, interlock present and no overtemperature
// [RULE6] operate lights green operate lamp; standby lights amber standby lamp
// [RULE7] alc passes to trays in operate, forced low in standby
// [RULE8] both amplifier disables off in operate, on in standby
// [RULE9] four tray enables on in operate, all off in standby
// [RULE10] active-low remote operate output driven in operate only
// [RULE11] auto latch: auto sets, manual clears, otherwise holds
// [RULE12] in auto fault logic governs operate; panel standby is ignored
// [RULE13] auto lights automatic lamp, asserts remote auto, drops remote manual
// [RULE14] manual lights manual lamp, asserts active-low remote manual output
// [RULE15] in manual only panel operate/standby commands move the operate latch
// [RULE16] low video fault input means loss; video loss lamp follows it
// [RULE17] combined fault is video loss or receiver alc fault
// [RULE18] auto with combined fault releases operate, asserts standby
// [RULE19] auto with fault cleared asserts operate, releases standby
// [RULE20] auto standby waits for persistent video loss; recovery is immediate
// [RULE21] simultaneous operate and standby on the latch: standby wins
`timescale 1ns/100ps
`default_nettype none
module transmitter_operate_auto_control #(
   parameter logic [31:0] VIDEO_HOLD_CYC = 32'(txctl_pkg::VIDEO_HOLD_CYC)
) (
   input wire logic i_ref_clk,
   input wire logic i_rst,
   // panel switch commands, high while pressed
   input wire logic i_operate_standby_switch_op,
   input wire logic i_operate_standby_switch_sb,
   input wire logic i_auto_manual_switch_auto,
   input wire logic i_auto_manual_switch_man,
   // field inputs
   input wire logic i_interlock_input_n,
   input wire logic i_video_fault_input_n,
   input wire logic i_rx_alc_fault,
   input wire logic i_overtemp_fault,
   input wire logic i_vswr_over_limit,
   input wire logic [3:0] i_alc,
   // indicators
   output logic o_standby_indicator,
   output logic o_operate_indicator,
   output logic o_automatic_indicator,
   output logic o_manual_indicator,
   output logic o_interlock_indicator,
   output logic o_video_loss_indicator,
   // tray and remote drive
   output logic [3:0] o_alc,
   output logic o_cutback,
   output logic o_amp_disable_a,
   output logic o_amp_disable_b,
   output logic [3:0] o_tray_enable,
   output logic o_remote_operate_out_n,
   output logic o_remote_auto_out_n,
   output logic o_remote_manual_out_n,
   output logic o_operating
);
   logic operate_latch;
   logic auto_latch;
   logic video_lost;
   logic interlock_ok;
   logic combined_fault;
   logic auto_operate_gate;
   logic auto_standby_gate;
   logic op_set;
   logic op_clr;
   logic operate_qualify_gate;

   // input conditions, interlock and video are active low
   assign interlock_ok = !i_interlock_input_n;
   assign combined_fault = video_lost || i_rx_alc_fault; // [RULE17]

   // fault-driven commands only act in auto
   assign auto_operate_gate = auto_latch && !combined_fault; // [RULE19]
   assign auto_standby_gate = auto_latch && combined_fault; // [RULE18]

   // in auto the panel standby is blocked; manual ignores the fault gates
   assign op_set = auto_latch ? auto_operate_gate : i_operate_standby_switch_op; // [RULE15]
   assign op_clr = auto_latch ? auto_standby_gate : i_operate_standby_switch_sb; // [RULE12]

   // operate qualified by interlock and temperature
   assign operate_qualify_gate = operate_latch && interlock_ok && // [RULE1]
                                 !i_overtemp_fault; // [RULE5]

   // persistence filter on raw video loss
   video_loss_timer #(
      .HOLD_CYC(VIDEO_HOLD_CYC)
   ) u_vid (
      .i_ref_clk(i_ref_clk),
      .i_rst(i_rst),
      .i_loss(!i_video_fault_input_n), // [RULE20]
      .o_lost(video_lost)
   );

   // operate/standby relay
   cmd_latch #(
      .RST_VAL(txctl_pkg::OPERATE_RST)
   ) u_op (
      .i_ref_clk(i_ref_clk),
      .i_rst(i_rst),
      .i_set(op_set), // [RULE4]
      .i_clr(op_clr), // [RULE21]
      .o_q(operate_latch)
   );

   // auto/manual relay; manual wins a tie, the safe side
   cmd_latch #(
      .RST_VAL(txctl_pkg::AUTO_RST)
   ) u_auto (
      .i_ref_clk(i_ref_clk),
      .i_rst(i_rst),
      .i_set(i_auto_manual_switch_auto), // [RULE11]
      .i_clr(i_auto_manual_switch_man),
      .o_q(auto_latch)
   );

   // operate-side drive, registered so outputs come from flops
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         o_operating <= 1'h0;
         o_operate_indicator <= 1'h0;
         o_standby_indicator <= 1'h1;
         o_alc <= txctl_pkg::TRAY_NONE;
         o_amp_disable_a <= 1'h1;
         o_amp_disable_b <= 1'h1;
         o_tray_enable <= txctl_pkg::TRAY_NONE;
         o_remote_operate_out_n <= 1'h1;
      end else begin
         o_operating <= operate_qualify_gate; // [RULE5]
         o_operate_indicator <= operate_qualify_gate; // [RULE6]
         o_standby_indicator <= !operate_qualify_gate; // [RULE6]
         o_alc <= operate_qualify_gate ? i_alc : txctl_pkg::TRAY_NONE; // [RULE7]
         o_amp_disable_a <= !operate_qualify_gate; // [RULE8]
         o_amp_disable_b <= !operate_qualify_gate; // [RULE8]
         o_tray_enable <= operate_qualify_gate ? txctl_pkg::TRAY_ALL
                                               : txctl_pkg::TRAY_NONE; // [RULE9]
         o_remote_operate_out_n <= !operate_qualify_gate; // [RULE10]
      end
   end

   // mode indicators
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         o_automatic_indicator <= 1'h0;
         o_manual_indicator <= 1'h1;
         o_remote_auto_out_n <= 1'h1;
         o_remote_manual_out_n <= 1'h0;
      end else begin
         o_automatic_indicator <= auto_latch; // [RULE13]
         o_remote_auto_out_n <= !auto_latch; // [RULE13]
         o_manual_indicator <= !auto_latch; // [RULE14]
         o_remote_manual_out_n <= auto_latch; // [RULE14]
      end
   end

   // status lamps and cutback; cutback is a level from the vswr comparator
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         o_interlock_indicator <= 1'h0;
         o_video_loss_indicator <= 1'h0;
         o_cutback <= 1'h0;
      end else begin
         o_interlock_indicator <= interlock_ok; // [RULE2]
         o_video_loss_indicator <= !i_video_fault_input_n; // unfiltered lamp [RULE16]
         o_cutback <= i_vswr_over_limit; // [RULE3]
      end
   end
endmodule
`default_nettype wire

// File: src/txctl_pkg.sv
// constants and types for the transmitter operate/auto control block
package txctl_pkg;
   // clock rate and timing
   localparam int unsigned CLK_HZ = 10_000_000;
   localparam int unsigned VIDEO_HOLD_MS = 3000;
   localparam int unsigned VIDEO_HOLD_CYC = (CLK_HZ / 1000) * VIDEO_HOLD_MS;
   localparam int unsigned HOLD_W = 32;
   // reset values
   localparam logic OPERATE_RST = 1'h0;
   localparam logic AUTO_RST = 1'h0;
   // number of amplifier-tray enables
   localparam int unsigned TRAY_N = 4;
   localparam logic [3:0] TRAY_ALL = 4'hf;
   localparam logic [3:0] TRAY_NONE = 4'h0;
   // video-loss qualifier states
   typedef enum logic [1:0] {
      VID_OK = 2'b00,
      VID_WAIT = 2'b01,
      VID_LOST = 2'b10
   } vid_state_t;
endpackage

// File: src/video_loss_timer.sv
// video loss persistence filter: loss must hold for the full time, recovery is immediate
`timescale 1ns/100ps
`default_nettype none
module video_loss_timer #(
   parameter logic [31:0] HOLD_CYC = 32'(txctl_pkg::VIDEO_HOLD_CYC)
) (
   input wire logic i_ref_clk,
   input wire logic i_rst,
   input wire logic i_loss,
   output logic o_lost
);
   txctl_pkg::vid_state_t state_ff;
   logic [txctl_pkg::HOLD_W-1:0] cnt_ff;

   // persistence state machine; a short glitch of video never reaches standby
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         state_ff <= txctl_pkg::VID_OK;
         cnt_ff <= '0;
      end else begin
         case (state_ff)
            txctl_pkg::VID_OK: begin
               cnt_ff <= '0;
               if (i_loss) begin
                  state_ff <= txctl_pkg::VID_WAIT;
               end
            end
            txctl_pkg::VID_WAIT: begin
               if (!i_loss) begin
                  state_ff <= txctl_pkg::VID_OK; // [RULE20]
               end else if (cnt_ff >= HOLD_CYC - 32'h1) begin
                  state_ff <= txctl_pkg::VID_LOST; // [RULE20]
               end else begin
                  cnt_ff <= cnt_ff + 32'h1;
               end
            end
            txctl_pkg::VID_LOST: begin
               if (!i_loss) begin
                  state_ff <= txctl_pkg::VID_OK; // at once on return [RULE20]
               end
            end
            default: state_ff <= txctl_pkg::VID_OK;
         endcase
      end
   end

   // filtered loss flag
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         o_lost <= 1'h0;
      end else begin
         o_lost <= (state_ff == txctl_pkg::VID_WAIT) && i_loss &&
                   (cnt_ff >= HOLD_CYC - 32'h1) ||
                   (state_ff == txctl_pkg::VID_LOST) && i_loss;
      end
   end
endmodule
`default_nettype wire
